// [bench/port_reader.sv]
// equipment model that samples the four output port levels
`default_nettype none
module port_reader (
    input wire logic i_ref_clk,
    input wire logic [3:0] i_port,
    output logic [3:0] o_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // listens only: the ports are never driven from this side
    always @(posedge i_ref_clk) begin
        o_seen <= i_port;
    end
endmodule // port_reader
`default_nettype wire

// [bench/status_output_port_routing_tb.sv]
// self-checking bench for the status port routing block
`default_nettype none
module status_output_port_routing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hd = 1'b0, mot = 1'b0;
    logic [1:0] id = 2'h0;
    logic [2:0] wd = 3'h0, lv = 3'h0, act, pend;
    logic [5:0] ev = 6'h0;
    logic [3:0] gen = 4'h0, seen, port, rb;
    logic signed [31:0] pos = 0, la = 0, lb = 0, cp = 0;
    logic vld, err, zf, hf, pf;
    logic ef = 1'b0, vf = 1'b0;
    int num_errors = 0, checks = 0, cyc = 0;
    // rows: shaft position, two limits, expected zone flag
    int rows [5][4] = '{'{5, 0, 10, 1}, '{0, 0, 10, 1}, '{10, 10, 0, 1}, '{11, 0, 10, 0},
        '{-3, -1, -5, 1}};
    status_output_port_routing dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sel_wr(wr),
        .i_sel_id(id), .i_sel_wdata(wd), .i_sel_rd(rd), .o_sel_rd_valid(vld),
        .o_sel_active(act), .o_sel_pending(pend), .o_sel_wr_err(err),
        .i_in_zone_active_level(lv[0]), .i_home_flag_active_level(lv[1]),
        .i_paused_flag_active_level(lv[2]), .i_shaft_position(pos), .i_zone_limit_a(la),
        .i_zone_limit_b(lb), .i_commanded_position(cp), .i_homing_done(hd),
        .i_motion_active(mot), .i_pause_command(ev[5]), .i_pause_input(ev[4]),
        .i_resume_command(ev[0]), .i_start_input(ev[1]), .i_pause_clear_input(ev[2]),
        .i_pause_clear_command(ev[3]), .i_gen_out(gen), .o_port(port),
        .o_gen_out_readback(rb), .o_zone_flag(zf), .o_home_position_flag(hf),
        .o_paused_flag(pf));
    port_reader u_reader (.i_ref_clk(clk), .i_port(port), .o_seen(seen));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // the run should need well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            end_sim;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        tick(12);
        rst_n = 1'b1;
        tick(12);
    endtask
    // one write or query strobe, then time for the answer to land
    task automatic sel(input logic w, input logic [1:0] i, input logic [2:0] d);
        wr = w;
        rd = ~w;
        id = i;
        wd = d;
        tick(1);
        // refusal pulse stands one cycle after the strobe edge, answer one later
        ef = err;
        wr = 1'b0;
        rd = 1'b0;
        tick(1);
        vf = vld;
        tick(2);
    endtask
    initial begin
        tick(1);
        do_reset;
        for (int i = 0; i < 3; i++) begin
            sel(1'b0, i[1:0], 3'h0);
            chk({2'h0, act, pend}, 8'h00);
            chk({7'h0, vf}, 8'h01);
        end
        $display("reset values done");
        for (int i = 0; i < 5; i++) begin
            pos = rows[i][0];
            la = rows[i][1];
            lb = rows[i][2];
            tick(2);
            chk({7'h0, zf}, rows[i][3][7:0]);
        end
        $display("zone done");
        sel(1'b1, 2'h0, 3'h2);
        sel(1'b1, 2'h1, 3'h3);
        sel(1'b1, 2'h2, 3'h4);
        chk({7'h0, ef}, 8'h00);
        sel(1'b1, 2'h2, 3'h5);
        chk({7'h0, ef}, 8'h01);
        sel(1'b1, 2'h3, 3'h1);
        chk({7'h0, ef}, 8'h01);
        sel(1'b0, 2'h2, 3'h0);
        chk({2'h0, act, pend}, 8'h04);
        gen = 4'ha;
        tick(4);
        chk({4'h0, seen}, 8'h0a);
        do_reset;
        sel(1'b0, 2'h2, 3'h0);
        chk({2'h0, act, pend}, 8'h24);
        tick(4);
        chk({seen, rb}, 8'hc0);
        lv = 3'h7;
        gen = 4'h5;
        tick(4);
        chk({seen, rb}, 8'h31);
        $display("routing done");
        hd = 1'b1;
        tick(1);
        hd = 1'b0;
        tick(4);
        chk({7'h0, hf}, 8'h01);
        cp = 5;
        tick(4);
        chk({7'h0, hf}, 8'h00);
        $display("home done");
        mot = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ev[4 + i % 2] = 1'b1;
            tick(1);
            ev = 6'h0;
            tick(4);
            chk({6'h0, pf, seen[3]}, 8'h03);
            ev[i] = 1'b1;
            tick(1);
            ev = 6'h0;
            tick(4);
            chk({6'h0, pf, seen[3]}, 8'h00);
        end
        $display("pause done");
        end_sim;
    end
endmodule // status_output_port_routing_tb
`default_nettype wire

// [bench/status_routing_props.sv]
// assertion checker for the status port routing block
`default_nettype none
module status_routing_props (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sel_wr,
    input wire logic [1:0] i_sel_id,
    input wire logic [2:0] i_sel_wdata,
    input wire logic i_sel_rd,
    input wire logic o_sel_rd_valid,
    input wire logic [2:0] o_sel_active,
    input wire logic [2:0] o_sel_pending,
    input wire logic o_sel_wr_err,
    input wire logic signed [31:0] i_shaft_position,
    input wire logic signed [31:0] i_zone_limit_a,
    input wire logic signed [31:0] i_zone_limit_b,
    input wire logic signed [31:0] i_commanded_position,
    input wire logic i_homing_done,
    input wire logic i_motion_active,
    input wire logic i_pause_command,
    input wire logic i_pause_input,
    input wire logic i_resume_command,
    input wire logic i_start_input,
    input wire logic i_pause_clear_input,
    input wire logic i_pause_clear_command,
    input wire logic o_zone_flag,
    input wire logic o_home_position_flag,
    input wire logic o_paused_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff;
    logic homed_ff;
    logic run;
    logic in_zone;
    logic clr;
    // wide settle window covers the sync flops and the selector reload
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 4'h0;
            homed_ff <= 1'b0;
        end else begin
            if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
            if (i_homing_done) homed_ff <= 1'b1;
        end
    end
    assign run = cnt_ff >= 4'hc;
    assign in_zone = (i_shaft_position >= i_zone_limit_a && i_shaft_position <= i_zone_limit_b)
        || (i_shaft_position >= i_zone_limit_b && i_shaft_position <= i_zone_limit_a);
    assign clr = i_resume_command | i_start_input | i_pause_clear_input | i_pause_clear_command;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    zone_flag_a: assert property (run |-> o_zone_flag == $past(in_zone))
        else $error("zone flag does not follow position");
    home_unhomed_a: assert property (run && !homed_ff |-> !o_home_position_flag)
        else $error("home flag set before homing");
    home_zero_a: assert property (run && $past(homed_ff, 2) |->
        o_home_position_flag == ($past(i_commanded_position) == 0))
        else $error("home flag does not track position zero");
    pause_set_a: assert property (run && i_motion_active && (i_pause_command || i_pause_input)
        |-> ##2 o_paused_flag)
        else $error("pause flag not set");
    pause_clear_a: assert property (run && clr && !i_pause_command && !i_pause_input
        |-> ##2 !o_paused_flag)
        else $error("pause flag not cleared");
    bad_write_a: assert property (run && i_sel_wr && (i_sel_wdata > 3'h4 || i_sel_id == 2'h3)
        |=> o_sel_wr_err)
        else $error("bad selector write not refused");
    query_valid_a: assert property (run && i_sel_rd && !i_sel_wr |-> ##2 o_sel_rd_valid)
        else $error("query answer missing");
    query_range_a: assert property (o_sel_rd_valid |-> o_sel_active <= 3'h4 && o_sel_pending <= 3'h4)
        else $error("selector out of range");
endmodule // status_routing_props
bind status_output_port_routing status_routing_props u_props (
    .i_ref_clk, .i_rst_n, .i_sel_wr, .i_sel_id, .i_sel_wdata, .i_sel_rd, .o_sel_rd_valid,
    .o_sel_active, .o_sel_pending, .o_sel_wr_err, .i_shaft_position, .i_zone_limit_a,
    .i_zone_limit_b, .i_commanded_position, .i_homing_done, .i_motion_active, .i_pause_command,
    .i_pause_input, .i_resume_command, .i_start_input, .i_pause_clear_input,
    .i_pause_clear_command, .o_zone_flag, .o_home_position_flag, .o_paused_flag
);
`default_nettype wire

// [hw/selector_store.v]
// nonvolatile selector store model: three 3-bit words, registered read
`default_nettype none
`include "status_port_consts.vh"
module selector_store (
    input wire i_ref_clk,
    input wire i_wr_en,
    input wire [`NV_AW-1:0] i_wr_addr,
    input wire [`SEL_W-1:0] i_wr_data,
    input wire [`NV_AW-1:0] i_rd_addr,
    output reg [`SEL_W-1:0] o_rd_data
);
    // no reset: contents stand for stored values that survive power loss
    reg [`SEL_W-1:0] mem [0:`NV_DEPTH-1];
    integer k;
    initial begin
        for (k = 0; k < `NV_DEPTH; k = k + 1) begin
            mem[k] = `SEL_NONE;
        end
        o_rd_data = `SEL_NONE;
    end
    always @(posedge i_ref_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
    end
endmodule // selector_store
`default_nettype wire

// [hw/status_output_port_routing.v]
// routes zone, home and pause flags onto four output ports
// Notes on behaviour
// - selectors take 0..4, read and write
// - selectors start at zero, unassigned
// - new selector acts only after reset
// - writes stored nonvolatile with no save
// - zero routes nowhere, n routes port n
// - zone flag set inside zone limits
// - zone flag evaluated moving or stopped
// - each signal has its own polarity
// - home flag set at valid home
// - home flag off until homing succeeds
// - after homing, home flag when position zero
// - home flag recomputed every cycle
// - pause flag set on pause command/input while motion is active
// - pause flag clear when nothing paused
// - resume command or start clears pause
// - pause-clear input or command clears pause
// - assigned port ignores general output value
`default_nettype none
`include "status_port_consts.vh"
module status_output_port_routing (
    input wire i_ref_clk,
    input wire i_rst_n,
    // selector access, one strobe per command
    input wire i_sel_wr,
    input wire [1:0] i_sel_id,
    input wire [`SEL_W-1:0] i_sel_wdata,
    input wire i_sel_rd,
    output reg o_sel_rd_valid,
    output reg [`SEL_W-1:0] o_sel_active,
    output reg [`SEL_W-1:0] o_sel_pending,
    output reg o_sel_wr_err,
    // polarity parameters: 1 = port high when flag set
    input wire i_in_zone_active_level,
    input wire i_home_flag_active_level,
    input wire i_paused_flag_active_level,
    // motion state
    input wire signed [`POS_W-1:0] i_shaft_position,
    input wire signed [`POS_W-1:0] i_zone_limit_a,
    input wire signed [`POS_W-1:0] i_zone_limit_b,
    input wire signed [`POS_W-1:0] i_commanded_position,
    input wire i_homing_done,
    input wire i_motion_active,
    input wire i_pause_command,
    input wire i_pause_input,
    input wire i_resume_command,
    input wire i_start_input,
    input wire i_pause_clear_input,
    input wire i_pause_clear_command,
    // general-purpose output value
    input wire [`NUM_PORTS-1:0] i_gen_out,
    output reg [`NUM_PORTS-1:0] o_port,
    output reg [`NUM_PORTS-1:0] o_gen_out_readback,
    output reg o_zone_flag,
    output reg o_home_position_flag,
    output reg o_paused_flag
);
    localparam [2:0] ST_LOAD0 = 3'h0;
    localparam [2:0] ST_LOAD1 = 3'h1;
    localparam [2:0] ST_LOAD2 = 3'h2;
    localparam [2:0] ST_LOAD3 = 3'h3;
    localparam [2:0] ST_RUN = 3'h4;

    // port mask for a selector; zero gives an empty mask
    function [`NUM_PORTS-1:0] port_mask;
        input [`SEL_W-1:0] sel;
        begin
            case (sel)
                3'h1: port_mask = 4'h1;
                3'h2: port_mask = 4'h2;
                3'h3: port_mask = 4'h4;
                3'h4: port_mask = 4'h8;
                default: port_mask = 4'h0;
            endcase
        end
    endfunction

    function [`SEL_W-1:0] active_of;
        input [1:0] id;
        input [`SEL_W-1:0] z;
        input [`SEL_W-1:0] h;
        input [`SEL_W-1:0] p;
        begin
            case (id)
                `SIG_ZONE: active_of = z;
                `SIG_HOME: active_of = h;
                default: active_of = p;
            endcase
        end
    endfunction

    reg rst_meta_ff;
    reg rst_sync_ff;
    wire rst_n = rst_sync_ff;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [`SEL_W-1:0] zone_sel_ff;
    reg [`SEL_W-1:0] home_sel_ff;
    reg [`SEL_W-1:0] pause_sel_ff;
    reg homed_ff;
    reg paused_ff;
    reg rd_pend_ff;
    reg [1:0] rd_id_ff;
    reg [`NV_AW-1:0] nv_rd_addr;
    wire [`SEL_W-1:0] nv_rd_data;

    wire sel_ok = (i_sel_wdata <= `SEL_MAX) && (i_sel_id <= `SIG_PAUSE);
    wire nv_wr = i_sel_wr && sel_ok && (state_ff == ST_RUN);

    selector_store u_store (
        .i_ref_clk(i_ref_clk),
        .i_wr_en(nv_wr),
        .i_wr_addr(i_sel_id),
        .i_wr_data(i_sel_wdata),
        .i_rd_addr(nv_rd_addr),
        .o_rd_data(nv_rd_data)
    );

    // after each reset the stored selectors are copied into the active set
    always @* begin
        nxt_state = state_ff;
        nv_rd_addr = i_sel_id;
        case (state_ff)
            ST_LOAD0: begin
                nv_rd_addr = `SIG_ZONE;
                nxt_state = ST_LOAD1;
            end
            ST_LOAD1: begin
                nv_rd_addr = `SIG_HOME;
                nxt_state = ST_LOAD2;
            end
            ST_LOAD2: begin
                nv_rd_addr = `SIG_PAUSE;
                nxt_state = ST_LOAD3;
            end
            ST_LOAD3: nxt_state = ST_RUN;
            ST_RUN: nv_rd_addr = i_sel_id;
            default: nxt_state = ST_LOAD0;
        endcase
    end

    always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_LOAD0;
            zone_sel_ff <= `SEL_NONE;
            home_sel_ff <= `SEL_NONE;
            pause_sel_ff <= `SEL_NONE;
        end else begin
            state_ff <= nxt_state;
            // active routing only loads here, never on a write
            if (state_ff == ST_LOAD1) begin
                zone_sel_ff <= nv_rd_data;
            end
            if (state_ff == ST_LOAD2) begin
                home_sel_ff <= nv_rd_data;
            end
            if (state_ff == ST_LOAD3) begin
                pause_sel_ff <= nv_rd_data;
            end
        end
    end

    // query: one cycle for the store read, answer on the next
    always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
            rd_id_ff <= `SIG_ZONE;
            o_sel_rd_valid <= 1'b0;
            o_sel_active <= `SEL_NONE;
            o_sel_pending <= `SEL_NONE;
            o_sel_wr_err <= 1'b0;
        end else begin
            rd_pend_ff <= i_sel_rd && !i_sel_wr && (state_ff == ST_RUN);
            rd_id_ff <= i_sel_id;
            o_sel_rd_valid <= rd_pend_ff;
            o_sel_wr_err <= i_sel_wr && !sel_ok;
            if (rd_pend_ff) begin
                o_sel_active <= active_of(rd_id_ff, zone_sel_ff, home_sel_ff,
                    pause_sel_ff);
                o_sel_pending <= nv_rd_data;
            end
        end
    end

    wire in_zone_lo_hi = (i_shaft_position >= i_zone_limit_a) &&
        (i_shaft_position <= i_zone_limit_b);
    wire in_zone_hi_lo = (i_shaft_position >= i_zone_limit_b) &&
        (i_shaft_position <= i_zone_limit_a);
    // limits may be given in either order; motion state is not consulted
    wire zone_now = in_zone_lo_hi || in_zone_hi_lo;

    wire clear_pause = i_resume_command || i_start_input ||
        i_pause_clear_input || i_pause_clear_command;
    wire set_pause = i_motion_active && (i_pause_command || i_pause_input);

    always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            homed_ff <= 1'b0;
            paused_ff <= 1'b0;
        end else begin
            if (i_homing_done) begin
                homed_ff <= 1'b1;
            end
            // a new pause wins over a clear in the same cycle
            if (set_pause) begin
                paused_ff <= 1'b1;
            end else if (clear_pause) begin
                paused_ff <= 1'b0;
            end
        end
    end

    wire home_now = homed_ff && (i_commanded_position == `POS_ZERO);

    reg [`NUM_PORTS-1:0] nxt_port;
    reg [`NUM_PORTS-1:0] nxt_readback;
    reg [`NUM_PORTS-1:0] owned;
    always @* begin
        owned = port_mask(zone_sel_ff) | port_mask(home_sel_ff) |
            port_mask(pause_sel_ff);
        nxt_port = i_gen_out & ~owned;
        nxt_readback = i_gen_out & ~owned;
        // a port picked by two selectors shows the later signal here
        if (zone_sel_ff != `SEL_NONE) begin
            nxt_port = (nxt_port & ~port_mask(zone_sel_ff)) |
                ((zone_now == i_in_zone_active_level) ? port_mask(zone_sel_ff) :
                4'h0);
        end
        if (home_sel_ff != `SEL_NONE) begin
            nxt_port = (nxt_port & ~port_mask(home_sel_ff)) |
                ((home_now == i_home_flag_active_level) ? port_mask(home_sel_ff) :
                4'h0);
        end
        if (pause_sel_ff != `SEL_NONE) begin
            nxt_port = (nxt_port & ~port_mask(pause_sel_ff)) |
                ((paused_ff == i_paused_flag_active_level) ?
                port_mask(pause_sel_ff) : 4'h0);
        end
    end

    always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_port <= 4'h0;
            o_gen_out_readback <= 4'h0;
            o_zone_flag <= 1'b0;
            o_home_position_flag <= 1'b0;
            o_paused_flag <= 1'b0;
        end else if (state_ff == ST_RUN) begin
            o_port <= nxt_port;
            o_gen_out_readback <= nxt_readback;
            o_zone_flag <= zone_now;
            o_home_position_flag <= home_now;
            o_paused_flag <= paused_ff;
        end
    end
endmodule // status_output_port_routing
`default_nettype wire

// [hw/status_port_consts.vh]
// constants for the status output port routing block
`ifndef STATUS_PORT_CONSTS_VH
`define STATUS_PORT_CONSTS_VH
`define SEL_W 3
`define SEL_MAX 3'h4
`define SEL_NONE 3'h0
`define NUM_PORTS 4
`define POS_W 32
`define SIG_ZONE 2'h0
`define SIG_HOME 2'h1
`define SIG_PAUSE 2'h2
`define NV_DEPTH 3
`define NV_AW 2
`define POS_ZERO 32'h00000000
`endif
